/* verilog/iem_irq_enable_mask.sv */
`timescale 1ns/1ps
`default_nettype none
module iem_irq_enable_mask
    import iem_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] attach_cond,
    input  wire logic [6:0] fault_cond,
    input  wire logic [7:0] aux_cond,
    output logic            irq_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  enable_group0_r;
        logic [7:0]  enable_group1_r;
        logic [7:0]  enable_group2_r;
        logic [20:0] sync1_r;
        logic [20:0] sync2_r;
        logic [7:0]  rdata_r;
        logic        irq_r;
    } iem_top_t;

    iem_top_t st_r;
    iem_top_t st_nxt;

    // ----------------------------------------
    // Decode, fields and group wiring
    // ----------------------------------------
    logic [7:0]                 flags0;
    logic [7:0]                 flags1;
    logic [7:0]                 flags2;
    logic [7:0]                 rd_mux;
    logic [IEM_GROUPS-1:0]      hit_enable;
    logic [IEM_GROUPS-1:0]      hit_flag;
    logic [IEM_GROUPS-1:0][7:0] grp_cond;
    logic [IEM_GROUPS-1:0][7:0] grp_enable;
    logic [IEM_GROUPS-1:0][7:0] grp_flags;
    logic [IEM_GROUPS-1:0]      grp_active;
    logic [IEM_GROUPS-1:0]      rd_clear;
    logic                       irq_any;
    logic                       flag_self_clear_mode;
    logic                       typec_state_event_enable;
    logic                       typec_attach_status_enable;
    logic                       bcdet_attach_status_enable;
    logic                       typec_attach_event_enable;
    logic                       bcdet_attach_event_enable;
    logic                       conversion_done_enable;
    logic                       bus_pre_overvolt_enable;
    logic                       bus_limit_undervolt_enable;
    logic                       bus_current_limit_enable;
    logic                       bus_overvolt_enable;
    logic                       bus_undervolt_enable;
    logic                       bus_short_ground_enable;
    logic                       thermal_shutdown_enable;

    // Group 2 layout is still open, so all its flag positions exist
    localparam logic [IEM_GROUPS-1:0][7:0] GRP_IMPL = {
        IEM_FLAGS_GROUP2,
        IEM_FLAGS_GROUP1,
        IEM_FLAGS_GROUP0
    };

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        hit_enable = '0;
        hit_flag   = '0;
        if (reg_addr == IEM_OFS_ENABLE_GROUP0) begin
            hit_enable[0] = 1'b1;
        end else if (reg_addr == IEM_OFS_ENABLE_GROUP1) begin
            hit_enable[1] = 1'b1;
        end else if (reg_addr == IEM_OFS_ENABLE_GROUP2) begin
            hit_enable[2] = 1'b1;
        end else if (reg_addr == IEM_OFS_FLAG_GROUP0) begin
            hit_flag[0] = 1'b1;
        end else if (reg_addr == IEM_OFS_FLAG_GROUP1) begin
            hit_flag[1] = 1'b1;
        end else if (reg_addr == IEM_OFS_FLAG_GROUP2) begin
            hit_flag[2] = 1'b1;
        end
    end

    // ----------------------------------------
    // Enable fields
    // ----------------------------------------
    assign flag_self_clear_mode       = st_r.enable_group0_r[IEM_BIT_SELF_CLEAR];
    assign typec_state_event_enable   = st_r.enable_group0_r[IEM_BIT_TYPEC_STATE_EV];
    assign typec_attach_status_enable = st_r.enable_group0_r[IEM_BIT_TYPEC_ATT_ST];
    assign bcdet_attach_status_enable = st_r.enable_group0_r[IEM_BIT_BCDET_ATT_ST];
    assign typec_attach_event_enable  = st_r.enable_group0_r[IEM_BIT_TYPEC_ATT_EV];
    assign bcdet_attach_event_enable  = st_r.enable_group0_r[IEM_BIT_BCDET_ATT_EV];
    assign conversion_done_enable     = st_r.enable_group0_r[IEM_BIT_ADC_DONE];
    assign bus_pre_overvolt_enable    = st_r.enable_group1_r[IEM_BIT_BUS_PRE_OV];
    assign bus_limit_undervolt_enable = st_r.enable_group1_r[IEM_BIT_BUS_LIM_UV];
    assign bus_current_limit_enable   = st_r.enable_group1_r[IEM_BIT_BUS_ILIM];
    assign bus_overvolt_enable        = st_r.enable_group1_r[IEM_BIT_BUS_OV];
    assign bus_undervolt_enable       = st_r.enable_group1_r[IEM_BIT_BUS_UV];
    assign bus_short_ground_enable    = st_r.enable_group1_r[IEM_BIT_BUS_SHORT];
    assign thermal_shutdown_enable    = st_r.enable_group1_r[IEM_BIT_THERMAL_SHD];

    // one enable per flag; the mode bit never gates a flag
    always_comb begin
        grp_enable = '0;
        grp_enable[0][IEM_BIT_TYPEC_STATE_EV] = typec_state_event_enable;
        grp_enable[0][IEM_BIT_TYPEC_ATT_ST]   = typec_attach_status_enable;
        grp_enable[0][IEM_BIT_BCDET_ATT_ST]   = bcdet_attach_status_enable;
        grp_enable[0][IEM_BIT_TYPEC_ATT_EV]   = typec_attach_event_enable;
        grp_enable[0][IEM_BIT_BCDET_ATT_EV]   = bcdet_attach_event_enable;
        grp_enable[0][IEM_BIT_ADC_DONE]       = conversion_done_enable;
        grp_enable[1][IEM_BIT_BUS_PRE_OV]     = bus_pre_overvolt_enable;
        grp_enable[1][IEM_BIT_BUS_LIM_UV]     = bus_limit_undervolt_enable;
        grp_enable[1][IEM_BIT_BUS_ILIM]       = bus_current_limit_enable;
        grp_enable[1][IEM_BIT_BUS_OV]         = bus_overvolt_enable;
        grp_enable[1][IEM_BIT_BUS_UV]         = bus_undervolt_enable;
        grp_enable[1][IEM_BIT_BUS_SHORT]      = bus_short_ground_enable;
        grp_enable[1][IEM_BIT_THERMAL_SHD]    = thermal_shutdown_enable;
        grp_enable[2]                         = st_r.enable_group2_r;
    end

    // ----------------------------------------
    // Synchronised conditions
    // ----------------------------------------
    assign grp_cond[0] = {2'b00, st_r.sync2_r[5:0]};
    assign grp_cond[1] = {1'b0, st_r.sync2_r[12:6]};
    assign grp_cond[2] = st_r.sync2_r[20:13];

    // ----------------------------------------
    // Flag groups
    // ----------------------------------------
    for (genvar g = 0; g < IEM_GROUPS; g++) begin : gen_grp
        assign rd_clear[g] = reg_rd && hit_flag[g];

        iem_flag_group #(
            .WIDTH (8),
            .IMPL  (GRP_IMPL[g])
        ) u_grp (
            .clk        (clk),
            .reset_n    (reset_n),
            .cond_sync  (grp_cond[g]),
            .self_clear (flag_self_clear_mode),
            .read_clear (rd_clear[g]),
            .enable     (grp_enable[g]),
            .flags      (grp_flags[g]),
            .active     (grp_active[g])
        );
    end

    assign flags0  = grp_flags[0];
    assign flags1  = grp_flags[1];
    assign flags2  = grp_flags[2];
    assign irq_any = |grp_active;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Unmapped addresses read zero, not the last register seen
    always_comb begin
        rd_mux = 8'h00;
        if (hit_enable[0]) begin
            rd_mux = st_r.enable_group0_r;
        end else if (hit_enable[1]) begin
            rd_mux = st_r.enable_group1_r;
        end else if (hit_enable[2]) begin
            rd_mux = st_r.enable_group2_r;
        end else if (hit_flag[0]) begin
            rd_mux = flags0;
        end else if (hit_flag[1]) begin
            rd_mux = flags1;
        end else if (hit_flag[2]) begin
            rd_mux = flags2;
        end
    end

    // ----------------------------------------
    // Register access and interrupt
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Conditions come from analog detectors
        st_nxt.sync1_r = {aux_cond, fault_cond, attach_cond};
        st_nxt.sync2_r = st_r.sync1_r;
        if (reg_wr) begin
            if (hit_enable[0]) begin
                // group 0 enables and mode bit
                st_nxt.enable_group0_r = reg_wdata & IEM_WMASK_GROUP0;
            end else if (hit_enable[1]) begin
                st_nxt.enable_group1_r = reg_wdata & IEM_WMASK_GROUP1;
            end else if (hit_enable[2]) begin
                st_nxt.enable_group2_r = reg_wdata & IEM_WMASK_GROUP2;
            end
        end
        st_nxt.rdata_r = rd_mux;
        st_nxt.irq_r   = irq_any;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata_r;
    assign irq_out   = st_r.irq_r;
endmodule
`default_nettype wire

/* verilog/iem_pkg.sv */
package iem_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] IEM_OFS_ENABLE_GROUP0 = 8'h07;
    localparam logic [7:0] IEM_OFS_ENABLE_GROUP1 = 8'h08;
    localparam logic [7:0] IEM_OFS_ENABLE_GROUP2 = 8'h09;
    localparam logic [7:0] IEM_OFS_FLAG_GROUP0   = 8'h0a;
    localparam logic [7:0] IEM_OFS_FLAG_GROUP1   = 8'h0b;
    localparam logic [7:0] IEM_OFS_FLAG_GROUP2   = 8'h0c;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IEM_BIT_SELF_CLEAR     = 7;
    localparam int IEM_BIT_TYPEC_STATE_EV = 5;
    localparam int IEM_BIT_TYPEC_ATT_ST   = 4;
    localparam int IEM_BIT_BCDET_ATT_ST   = 3;
    localparam int IEM_BIT_TYPEC_ATT_EV   = 2;
    localparam int IEM_BIT_BCDET_ATT_EV   = 1;
    localparam int IEM_BIT_ADC_DONE       = 0;
    localparam int IEM_BIT_BUS_PRE_OV     = 6;
    localparam int IEM_BIT_BUS_LIM_UV     = 5;
    localparam int IEM_BIT_BUS_ILIM       = 4;
    localparam int IEM_BIT_BUS_OV         = 3;
    localparam int IEM_BIT_BUS_UV         = 2;
    localparam int IEM_BIT_BUS_SHORT      = 1;
    localparam int IEM_BIT_THERMAL_SHD    = 0;
    // ----------------------------------------
    // Writable masks and reset values
    // ----------------------------------------
    localparam logic [7:0] IEM_WMASK_GROUP0 = 8'hbf;
    localparam logic [7:0] IEM_WMASK_GROUP1 = 8'h7f;
    localparam logic [7:0] IEM_WMASK_GROUP2 = 8'hff;
    localparam logic [7:0] IEM_FLAGS_GROUP0 = 8'h3f;
    localparam logic [7:0] IEM_FLAGS_GROUP1 = 8'h7f;
    localparam logic [7:0] IEM_FLAGS_GROUP2 = 8'hff;
    localparam logic [7:0] IEM_RESET_ENABLE = 8'h00;
    localparam int         IEM_GROUPS       = 3;
endpackage

/* verilog/iem_flag_group.sv */
`timescale 1ns/1ps
`default_nettype none
module iem_flag_group
    import iem_pkg::*;
#(
    parameter int         WIDTH    = 8,
    parameter logic [7:0] IMPL     = 8'hff
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] cond_sync,
    input  wire logic             self_clear,
    input  wire logic             read_clear,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] flags,
    output logic                  active
);
    typedef struct packed {
        logic [WIDTH-1:0] flag_r;
        logic [WIDTH-1:0] cond_d_r;
        logic             active_r;
    } iem_grp_t;

    iem_grp_t st_r;
    iem_grp_t st_nxt;
    logic [WIDTH-1:0] rise;

    always_comb begin
        st_nxt = st_r;
        rise = cond_sync & ~st_r.cond_d_r;
        st_nxt.cond_d_r = cond_sync;
        if (self_clear) begin
            st_nxt.flag_r = cond_sync & IMPL[WIDTH-1:0];
        end else begin
            // latch until read; new event wins over read clear
            st_nxt.flag_r = ((read_clear ? '0 : st_r.flag_r) | rise) & IMPL[WIDTH-1:0];
        end
        st_nxt.active_r = |(st_nxt.flag_r & enable);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags  = st_r.flag_r;
    assign active = st_r.active_r;
endmodule
`default_nettype wire

/* dv/iem_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module iem_sva (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] attach_cond,
    input wire logic [6:0] fault_cond,
    input wire logic [7:0] aux_cond,
    input wire logic       irq_out
);
    logic [7:0] e0_r, e1_r, e2_r;
    logic       sc, off, zc, hot, q0, g12;
    // Enables are hidden behind the ports, so shadow them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {e0_r, e1_r, e2_r} <= 24'h0;
        end else if (reg_wr) begin
            if (reg_addr == 8'h07) e0_r <= reg_wdata & 8'hbf;
            if (reg_addr == 8'h08) e1_r <= reg_wdata & 8'h7f;
            if (reg_addr == 8'h09) e2_r <= reg_wdata;
        end
    end
    assign sc  = e0_r[7];
    assign off = ((e0_r & 8'h3f) | e1_r | e2_r) == 8'h00;
    assign zc  = {attach_cond, fault_cond, aux_cond} == 21'h0;
    assign hot = |{attach_cond & e0_r[5:0], fault_cond & e1_r[6:0], aux_cond & e2_r};
    assign q0  = !reg_wr && attach_cond == 6'h00;
    assign g12 = !sc && (e1_r | e2_r) == 8'h00;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_rst; $rose(reset_n) |-> !irq_out && reg_rdata == 8'h00; endproperty
    property p_g0;
        reg_wr && reg_addr == 8'h07 ##1 !reg_wr && reg_addr == 8'h07
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'hbf);
    endproperty
    property p_g1;
        reg_wr && reg_addr == 8'h08 ##1 !reg_wr && reg_addr == 8'h08
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f);
    endproperty
    property p_mask; off [*6] |-> !irq_out; endproperty
    property p_rise; (sc && hot) [*7] |-> irq_out; endproperty
    property p_drop; (sc && zc) [*7] |-> !irq_out; endproperty
    // Quiet before the read too, so no rise is still in the synchroniser
    property p_rclr; q0 [*4] ##0 (reg_rd && reg_addr == 8'h0a && g12) ##1 q0 [*4] |-> !irq_out;
    endproperty
    property p_hold; (!reg_wr && !reg_rd) [*3] ##0 (irq_out && !sc) |=> irq_out; endproperty
    a_rst: assert property (p_rst) else $error("not quiet after reset");
    a_g0: assert property (p_g0) else $error("group0 readback");
    a_g1: assert property (p_g1) else $error("group1 readback");
    a_mask: assert property (p_mask) else $error("masked irq");
    a_rise: assert property (p_rise) else $error("enabled flag, no irq");
    a_drop: assert property (p_drop) else $error("irq after condition gone");
    a_rclr: assert property (p_rclr) else $error("read did not clear");
    a_hold: assert property (p_hold) else $error("latched irq dropped");
    c_sc: cover property (sc && irq_out);
    c_lat: cover property (!sc && irq_out);
    c_rd: cover property (reg_rd && reg_addr == 8'h0a);
endmodule
bind iem_irq_enable_mask iem_sva u_sva (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .attach_cond(attach_cond), .fault_cond(fault_cond), .aux_cond(aux_cond), .irq_out(irq_out));
`default_nettype wire

/* dv/iem_host.sv */
`timescale 1ns/1ps
`default_nettype none
module iem_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var logic  [7:0] reg_addr,
    output var logic        reg_wr,
    output var logic        reg_rd,
    output var logic  [7:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
    // Idle edge after each strobe, so two strobes never touch
    task automatic xfer(input logic [7:0] ad, input logic w, input logic r,
                        input logic [7:0] wd, output logic [7:0] d);
        {reg_addr, reg_wr, reg_rd, reg_wdata} = {ad, w, r, wd};
        @(posedge clk);
        #1 d = reg_rdata;
        {reg_wr, reg_rd} = 2'b00;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* dv/tb_irq_enable_mask_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_irq_enable_mask_logic;
    logic       clk, rst_n, wr, rd, irq;
    logic [7:0] a, wd, q, aux, d;
    logic [5:0] att;
    logic [6:0] flt;
    int         miscompares, checks;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    iem_irq_enable_mask DUT (.clk(clk), .reset_n(rst_n), .reg_addr(a), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wd), .reg_rdata(q), .attach_cond(att), .fault_cond(flt),
        .aux_cond(aux), .irq_out(irq));
    iem_host u_host (.clk(clk), .reg_rdata(q), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wd));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrr(input logic [7:0] ad, input logic [7:0] v);
        u_host.xfer(ad, 1'b1, 1'b0, v, d);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic c, input logic [7:0] e);
        u_host.xfer(ad, 1'b0, c, 8'h00, d);
        chk($sformatf("reg %h", ad), d, e);
    endtask
    // Latency is four edges; eight leaves margin
    task automatic irq_is(input logic e);
        repeat (8) @(posedge clk);
        #1 chk("irq", {7'h0, irq}, {7'h0, e});
    endtask
    task automatic t_reset;
        for (int i = 7; i < 10; i++) rdc(i[7:0], 1'b0, 8'h00);
        irq_is(1'b0);
        rdc(8'h0a, 1'b1, 8'h3f);
        rdc(8'h0b, 1'b1, 8'h7f);
        rdc(8'h0c, 1'b1, 8'hff);
        rdc(8'h0a, 1'b0, 8'h00);
        {att, flt, aux} = 21'h0;
        $display("reset test done");
    endtask
    task automatic t_regs;
        wrr(8'h07, 8'hff);
        rdc(8'h07, 1'b0, 8'hbf);
        wrr(8'h08, 8'hff);
        rdc(8'h08, 1'b0, 8'h7f);
        wrr(8'h09, 8'ha5);
        rdc(8'h09, 1'b0, 8'ha5);
        rdc(8'h20, 1'b0, 8'h00);
        $display("register test done");
    endtask
    task automatic t_latch;
        wrr(8'h07, 8'h01);
        wrr(8'h08, 8'h00);
        wrr(8'h09, 8'h00);
        att = 6'h02;
        irq_is(1'b0);
        att = 6'h03;
        repeat (3) @(posedge clk);
        #1 att = 6'h00;
        irq_is(1'b1);
        rdc(8'h0a, 1'b1, 8'h03);
        irq_is(1'b0);
        $display("latched test done");
    endtask
    task automatic t_self;
        wrr(8'h07, 8'h80);
        wrr(8'h08, 8'h08);
        flt = 7'h08;
        irq_is(1'b1);
        rdc(8'h0b, 1'b0, 8'h08);
        flt = 7'h00;
        irq_is(1'b0);
        rdc(8'h0b, 1'b0, 8'h00);
        wrr(8'h09, 8'h10);
        aux = 8'h30;
        irq_is(1'b1);
        aux = 8'h20;
        irq_is(1'b0);
        aux = 8'h00;
        $display("self clear test done");
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        {att, flt, aux} = 21'h1fffff;
        miscompares = 0;
        checks = 0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_regs();
        t_latch();
        t_self();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
